//--- hw/pls_supervisor.v
// power loss state supervisor of the board supervisor controller
`timescale 1ns/1ps
`default_nettype none
`include "pls_map.vh"

module pls_supervisor #(
  parameter [`PLS_WATCH_WIDTH-1:0] WATCH_CYCLES = `PLS_WATCH_CYCLES
) (
  // clock and reset
  input wire REF_CLK,
  input wire RST,
  // supply sensing and strap
  input wire STBY_OK,
  input wire AT_SUPPLY,
  // recovery policy selection
  input wire [1:0] POLICY,
  input wire POLICY_WR,
  // wake sources
  input wire PWRBTN_EVT,
  input wire SLPBTN_EVT,
  input wire SMBALERT_N,
  input wire WAKE_REQ,
  // host power requests
  input wire OFF_REQ,
  input wire SLEEP_REQ,
  input wire [1:0] SLP_TYPE,
  input wire DEEP_REQ,
  input wire S5E_EN,
  // power controls
  output wire SYS_PWR_EN,
  output wire ISLAND_ONLY,
  output wire CTX_RETAIN,
  output wire [1:0] RESUME_TYPE,
  output wire S5E_ACTIVE,
  // status and events
  output wire LOSS_EVT,
  output wire PROPER_OFF_EVT,
  output wire WAKE_EVT,
  output wire LAST_ON,
  output wire [1:0] POLICY_ACT
);

  // ****************************************************************
  // states
  // ****************************************************************
  localparam [8:0] ST_BOOT = 9'h001;
  localparam [8:0] ST_OFF = 9'h002;
  localparam [8:0] ST_ON = 9'h004;
  localparam [8:0] ST_SLEEP = 9'h008;
  localparam [8:0] ST_DEEP = 9'h010;
  localparam [8:0] ST_S5E = 9'h020;
  localparam [8:0] ST_WATCH = 9'h040;
  localparam [8:0] ST_LOSS = 9'h080;
  localparam [8:0] ST_RECOVER = 9'h100;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function recover_on;
    input [1:0] pol;
    input last_on;
    input at_sup;
    begin
      if (at_sup) begin
        recover_on = 1'b1;
      end else begin
        case (pol)
          `PLS_POL_TURN_ON: recover_on = 1'b1;
          `PLS_POL_REMAIN_OFF: recover_on = 1'b0;
          `PLS_POL_LAST_STATE: recover_on = last_on;
          default: recover_on = 1'b0;
        endcase
      end
    end
  endfunction

  function [1:0] flags_word;
    input loss;
    input last_on;
    begin
      flags_word = 2'h0;
      flags_word[`PLS_NV_BIT_LOSS] = loss;
      flags_word[`PLS_NV_BIT_LAST_ON] = last_on;
    end
  endfunction

  // ****************************************************************
  // declarations
  // ****************************************************************
  reg [8:0] state_q, state_d;
  reg stby_q;
  reg at_q;
  reg strap_done_q;
  reg smba_q;
  reg [1:0] boot_cnt_q, boot_cnt_d;
  reg [1:0] pol_q, pol_d;
  reg [1:0] flags_q, flags_d;
  reg fl_wr_d;
  reg pol_pend_q, pol_pend_d;
  reg nv_we_q, nv_we_d;
  reg nv_waddr_q, nv_waddr_d;
  reg [1:0] nv_wdata_q, nv_wdata_d;
  reg nv_raddr_q, nv_raddr_d;
  reg [1:0] deep_from_q, deep_from_d;
  reg [1:0] slp_type_q, slp_type_d;
  reg retain_q, retain_d;
  reg loss_evt_q, loss_evt_d;
  reg off_evt_q, off_evt_d;
  reg wake_evt_q, wake_evt_d;
  reg tmr_start_d;
  reg tmr_abort_d;
  reg pwr_q, island_q, s5e_q;
  wire [1:0] nv_rdata;
  wire tmr_expired;
  wire smba_fall;
  wire s5e_wake;

  // ****************************************************************
  // sub-blocks
  // ****************************************************************
  pls_nvstore #(
    .WIDTH(2),
    .AW(1)
  ) u_nv (
    .clk(REF_CLK),
    .rst(RST),
    .we(nv_we_q),
    .waddr(nv_waddr_q),
    .wdata(nv_wdata_q),
    .raddr(nv_raddr_q),
    .rdata(nv_rdata)
  );

  pls_timer #(
    .WIDTH(`PLS_WATCH_WIDTH),
    .LIMIT(WATCH_CYCLES)
  ) u_watch (
    .clk(REF_CLK),
    .rst(RST),
    .start(tmr_start_d),
    .abort(tmr_abort_d),
    .running(),
    .expired(tmr_expired)
  );

  assign smba_fall = smba_q & ~SMBALERT_N;
  assign s5e_wake = PWRBTN_EVT | SLPBTN_EVT | smba_fall;

  // ****************************************************************
  // next state
  // ****************************************************************
  always @* begin
    state_d = state_q;
    boot_cnt_d = boot_cnt_q;
    pol_d = pol_q;
    flags_d = flags_q;
    fl_wr_d = 1'b0;
    nv_raddr_d = nv_raddr_q;
    deep_from_d = deep_from_q;
    slp_type_d = slp_type_q;
    retain_d = retain_q;
    loss_evt_d = 1'b0;
    off_evt_d = 1'b0;
    wake_evt_d = 1'b0;
    tmr_start_d = 1'b0;
    tmr_abort_d = 1'b0;
    case (state_q)
      ST_BOOT: begin
        boot_cnt_d = boot_cnt_q + 2'h1;
        case (boot_cnt_q)
          2'h0: nv_raddr_d = `PLS_NV_ADDR_FLAGS;
          2'h1: pol_d = nv_rdata;
          default: begin
            flags_d = nv_rdata;
            boot_cnt_d = boot_cnt_q;
            if (strap_done_q) begin
              if (!stby_q) begin
                state_d = ST_LOSS;
              end else if (nv_rdata[`PLS_NV_BIT_LOSS]) begin
                state_d = ST_RECOVER;
              end else begin
                state_d = ST_OFF;
              end
            end
          end
        endcase
      end
      ST_OFF: begin
        if (PWRBTN_EVT) begin
          state_d = ST_ON;
          wake_evt_d = 1'b1;
        end
      end
      ST_ON: begin
        if (!flags_q[`PLS_NV_BIT_LAST_ON]) begin
          flags_d = flags_word(1'b0, 1'b1);
          fl_wr_d = 1'b1;
        end
        if (OFF_REQ || (SLEEP_REQ && SLP_TYPE == `PLS_SLP_S5)) begin
          state_d = ST_WATCH;
          tmr_start_d = 1'b1;
        end else if (SLEEP_REQ && SLP_TYPE != `PLS_SLP_NONE) begin
          state_d = ST_SLEEP;
          slp_type_d = SLP_TYPE;
        end
      end
      ST_SLEEP: begin
        if (DEEP_REQ) begin
          state_d = ST_DEEP;
          deep_from_d = slp_type_q;
          retain_d = (slp_type_q == `PLS_SLP_S3);
        end else if (WAKE_REQ || PWRBTN_EVT) begin
          state_d = ST_ON;
          wake_evt_d = 1'b1;
        end
      end
      ST_DEEP: begin
        if (WAKE_REQ || PWRBTN_EVT) begin
          state_d = ST_SLEEP;
          slp_type_d = deep_from_q;
          retain_d = 1'b0;
          wake_evt_d = 1'b1;
        end
      end
      ST_S5E: begin
        if (s5e_wake) begin
          state_d = ST_ON;
          wake_evt_d = 1'b1;
        end
      end
      ST_WATCH: begin
        if (tmr_expired) begin
          state_d = S5E_EN ? ST_S5E : ST_OFF;
          flags_d = flags_word(1'b0, 1'b0);
          fl_wr_d = 1'b1;
          off_evt_d = 1'b1;
        end
      end
      ST_LOSS: begin
        // only a classified loss applies the policy; a drop after a proper off stays off
        if (stby_q) begin
          state_d = flags_q[`PLS_NV_BIT_LOSS] ? ST_RECOVER : ST_OFF;
        end
      end
      ST_RECOVER: begin
        flags_d = flags_word(1'b0, recover_on(pol_q, flags_q[`PLS_NV_BIT_LAST_ON], at_q));
        fl_wr_d = 1'b1;
        state_d = recover_on(pol_q, flags_q[`PLS_NV_BIT_LAST_ON], at_q) ? ST_ON : ST_OFF;
      end
      default: begin
        state_d = ST_BOOT;
      end
    endcase
    // standby drop while running or within the window classifies a loss
    if (!stby_q && (state_q & (ST_ON | ST_SLEEP | ST_DEEP | ST_WATCH)) != 9'h000) begin
      state_d = ST_LOSS;
      tmr_abort_d = 1'b1;
      retain_d = 1'b0;
      loss_evt_d = 1'b1;
      // last state is kept as recorded, so a shutdown just before stays on
      flags_d = flags_word(1'b1, flags_q[`PLS_NV_BIT_LAST_ON]);
      fl_wr_d = 1'b1;
    end else if (!stby_q && (state_q & (ST_OFF | ST_S5E)) != 9'h000) begin
      state_d = ST_LOSS;
    end
    if (POLICY_WR) begin
      pol_d = POLICY;
    end
  end

  // ****************************************************************
  // retained store write arbitration
  // ****************************************************************
  always @* begin
    pol_pend_d = pol_pend_q | POLICY_WR;
    nv_we_d = 1'b0;
    nv_waddr_d = `PLS_NV_ADDR_FLAGS;
    nv_wdata_d = flags_d;
    if (fl_wr_d) begin
      nv_we_d = 1'b1;
    end else if (pol_pend_q) begin
      nv_we_d = 1'b1;
      nv_waddr_d = `PLS_NV_ADDR_POLICY;
      nv_wdata_d = pol_q;
      pol_pend_d = POLICY_WR;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state_q <= ST_BOOT;
      stby_q <= 1'b0;
      at_q <= 1'b0;
      strap_done_q <= 1'b0;
      smba_q <= 1'b1;
      boot_cnt_q <= 2'h0;
      pol_q <= `PLS_POL_RESET;
      flags_q <= `PLS_NV_FLAGS_RESET;
      pol_pend_q <= 1'b0;
      nv_we_q <= 1'b0;
      nv_waddr_q <= 1'b0;
      nv_wdata_q <= 2'h0;
      nv_raddr_q <= `PLS_NV_ADDR_POLICY;
      deep_from_q <= `PLS_SLP_NONE;
      slp_type_q <= `PLS_SLP_NONE;
      retain_q <= 1'b0;
      loss_evt_q <= 1'b0;
      off_evt_q <= 1'b0;
      wake_evt_q <= 1'b0;
      pwr_q <= 1'b0;
      island_q <= 1'b0;
      s5e_q <= 1'b0;
    end else begin
      stby_q <= STBY_OK;
      if (!strap_done_q) begin
        at_q <= AT_SUPPLY;
        strap_done_q <= 1'b1;
      end
      smba_q <= SMBALERT_N;
      state_q <= state_d;
      boot_cnt_q <= boot_cnt_d;
      pol_q <= pol_d;
      flags_q <= flags_d;
      pol_pend_q <= pol_pend_d;
      nv_we_q <= nv_we_d;
      nv_waddr_q <= nv_waddr_d;
      nv_wdata_q <= nv_wdata_d;
      nv_raddr_q <= nv_raddr_d;
      deep_from_q <= deep_from_d;
      slp_type_q <= slp_type_d;
      retain_q <= retain_d;
      loss_evt_q <= loss_evt_d;
      off_evt_q <= off_evt_d;
      wake_evt_q <= wake_evt_d;
      pwr_q <= (state_d == ST_ON);
      island_q <= (state_d == ST_DEEP);
      s5e_q <= (state_d == ST_S5E);
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign SYS_PWR_EN = pwr_q;
  assign ISLAND_ONLY = island_q;
  assign CTX_RETAIN = retain_q;
  assign RESUME_TYPE = slp_type_q;
  assign S5E_ACTIVE = s5e_q;
  assign LOSS_EVT = loss_evt_q;
  assign PROPER_OFF_EVT = off_evt_q;
  assign WAKE_EVT = wake_evt_q;
  assign LAST_ON = flags_q[`PLS_NV_BIT_LAST_ON];
  assign POLICY_ACT = pol_q;

endmodule // pls_supervisor

`default_nettype wire

//--- hw/pls_map.vh
// constants of the power loss state supervisor
`ifndef PLS_MAP_VH
`define PLS_MAP_VH

// ****************************************************************
// recovery policy codes
// ****************************************************************
`define PLS_POL_TURN_ON 2'h0
`define PLS_POL_REMAIN_OFF 2'h1
`define PLS_POL_LAST_STATE 2'h2
`define PLS_POL_RESET 2'h1

// ****************************************************************
// sleep type codes
// ****************************************************************
`define PLS_SLP_NONE 2'h0
`define PLS_SLP_S3 2'h1
`define PLS_SLP_S4 2'h2
`define PLS_SLP_S5 2'h3

// ****************************************************************
// retained store layout
// ****************************************************************
`define PLS_NV_ADDR_POLICY 1'h0
`define PLS_NV_ADDR_FLAGS 1'h1
`define PLS_NV_BIT_LAST_ON 0
`define PLS_NV_BIT_LOSS 1
`define PLS_NV_FLAGS_RESET 2'h0

// ****************************************************************
// timing
// ****************************************************************
`define PLS_CLK_HZ 50000000
`define PLS_WATCH_TIME_S 30
`define PLS_WATCH_CYCLES (`PLS_WATCH_TIME_S * `PLS_CLK_HZ)
`define PLS_WATCH_WIDTH 31

`endif

//--- hw/pls_nvstore.v
// small retained store for recovery policy and last power state
`timescale 1ns/1ps
`default_nettype none

module pls_nvstore #(
  parameter WIDTH = 2,
  parameter AW = 1
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // write port
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [WIDTH-1:0] wdata,
  // read port
  input wire [AW-1:0] raddr,
  output wire [WIDTH-1:0] rdata
);

  // ****************************************************************
  // storage, not cleared by reset: it models cells that keep content
  // ****************************************************************
  reg [WIDTH-1:0] mem [0:(1<<AW)-1];
  reg [WIDTH-1:0] rd_q;
  integer i;

  initial begin
    for (i = 0; i < (1<<AW); i = i + 1) begin
      mem[i] = {WIDTH{1'b0}};
    end
  end

  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_q <= {WIDTH{1'b0}};
    end else begin
      rd_q <= mem[raddr];
    end
  end

  assign rdata = rd_q;

endmodule // pls_nvstore

`default_nettype wire

//--- hw/pls_timer.v
// one-shot window timer
`timescale 1ns/1ps
`default_nettype none

module pls_timer #(
  parameter WIDTH = 31,
  parameter [WIDTH-1:0] LIMIT = 1
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // control
  input wire start,
  input wire abort,
  // status
  output wire running,
  output wire expired
);

  // ****************************************************************
  // counter
  // ****************************************************************
  reg [WIDTH-1:0] cnt_q;
  reg run_q;
  reg exp_q;
  wire last_w;

  assign last_w = (cnt_q == LIMIT - {{(WIDTH-1){1'b0}}, 1'b1});

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= {WIDTH{1'b0}};
      run_q <= 1'b0;
      exp_q <= 1'b0;
    end else begin
      exp_q <= 1'b0;
      if (abort) begin
        run_q <= 1'b0;
        cnt_q <= {WIDTH{1'b0}};
      end else if (start) begin
        run_q <= 1'b1;
        cnt_q <= {WIDTH{1'b0}};
      end else if (run_q) begin
        if (last_w) begin
          run_q <= 1'b0;
          exp_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  assign running = run_q;
  assign expired = exp_q;

endmodule // pls_timer

`default_nettype wire

//--- verification/pls_supervisor_properties.sv
// assertion checker of the power loss state supervisor
`timescale 1ns/1ps
`default_nettype none
`include "pls_map.vh"
module pls_supervisor_properties #(
  parameter [`PLS_WATCH_WIDTH-1:0] WATCH_CYCLES = `PLS_WATCH_CYCLES
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // inputs
  input wire logic STBY_OK,
  input wire logic OFF_REQ,
  input wire logic SLEEP_REQ,
  input wire logic [1:0] SLP_TYPE,
  input wire logic WAKE_REQ,
  input wire logic PWRBTN_EVT,
  input wire logic SLPBTN_EVT,
  input wire logic SMBALERT_N,
  // outputs
  input wire logic SYS_PWR_EN,
  input wire logic ISLAND_ONLY,
  input wire logic CTX_RETAIN,
  input wire logic [1:0] RESUME_TYPE,
  input wire logic S5E_ACTIVE,
  input wire logic LOSS_EVT,
  input wire logic PROPER_OFF_EVT,
  input wire logic LAST_ON
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // ****
  // cycles since the last shutdown request
  // ****
  logic [31:0] win_q;
  wire shut = SYS_PWR_EN && (OFF_REQ || (SLEEP_REQ && SLP_TYPE == `PLS_SLP_S5));
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) win_q <= 32'hFFFF_FFFF;
    else if (shut) win_q <= 32'h0000_0000;
    else if (win_q != 32'hFFFF_FFFF) win_q <= win_q + 32'h0000_0001;
  end
  // ****
  // properties
  // ****
  sequence deep_wake;
    ISLAND_ONLY && WAKE_REQ && STBY_OK;
  endsequence
  sequence s5e_wake;
    S5E_ACTIVE && STBY_OK && (PWRBTN_EVT || SLPBTN_EVT || $fell(SMBALERT_N));
  endsequence
  chk_loss_flagged: assert property ($fell(STBY_OK) && (SYS_PWR_EN || win_q < WATCH_CYCLES) |-> ##[1:4] LOSS_EVT)
    else $error("standby drop not flagged as loss");
  chk_loss_dark: assert property (LOSS_EVT |-> !SYS_PWR_EN && !ISLAND_ONLY && !S5E_ACTIVE)
    else $error("outputs live during loss");
  chk_window_length: assert property (PROPER_OFF_EVT |-> win_q >= WATCH_CYCLES && win_q <= WATCH_CYCLES + 4)
    else $error("proper off outside window");
  chk_off_records: assert property (PROPER_OFF_EVT |-> ##[0:2] !LAST_ON && !SYS_PWR_EN)
    else $error("last state not off after window");
  chk_shut_drops: assert property (shut |-> ##[1:3] !SYS_PWR_EN)
    else $error("power held after shutdown");
  chk_island_alone: assert property (ISLAND_ONLY |-> !SYS_PWR_EN && !S5E_ACTIVE)
    else $error("rails on in deep sleep");
  chk_ctx_entry: assert property (ISLAND_ONLY || CTX_RETAIN |-> ISLAND_ONLY && CTX_RETAIN == (RESUME_TYPE == `PLS_SLP_S3))
    else $error("context retention wrong");
  chk_deep_exit: assert property (deep_wake |-> ##[1:3] !ISLAND_ONLY && !SYS_PWR_EN)
    else $error("deep sleep resume wrong");
  chk_resume_kind: assert property (deep_wake |=> $stable(RESUME_TYPE) [*3])
    else $error("resume type changed");
  chk_s5e_wake: assert property (s5e_wake |-> ##[1:4] SYS_PWR_EN)
    else $error("soft off wake ignored");
endmodule // pls_supervisor_properties
bind pls_supervisor pls_supervisor_properties #(.WATCH_CYCLES(WATCH_CYCLES)) u_props (
  .REF_CLK(REF_CLK), .RST(RST), .STBY_OK(STBY_OK), .OFF_REQ(OFF_REQ), .SLEEP_REQ(SLEEP_REQ),
  .SLP_TYPE(SLP_TYPE), .WAKE_REQ(WAKE_REQ), .PWRBTN_EVT(PWRBTN_EVT), .SLPBTN_EVT(SLPBTN_EVT),
  .SMBALERT_N(SMBALERT_N), .SYS_PWR_EN(SYS_PWR_EN), .ISLAND_ONLY(ISLAND_ONLY), .CTX_RETAIN(CTX_RETAIN),
  .RESUME_TYPE(RESUME_TYPE), .S5E_ACTIVE(S5E_ACTIVE), .LOSS_EVT(LOSS_EVT),
  .PROPER_OFF_EVT(PROPER_OFF_EVT), .LAST_ON(LAST_ON));
`default_nettype wire

//--- verification/pls_atx_supply.sv
// carrier supply model with a standby rail
`timescale 1ns/1ps
`default_nettype none
module pls_atx_supply (
  // clock
  input wire logic clk,
  // mains and rail type
  input wire logic mains_on,
  input wire logic slow,
  input wire logic no_stby,
  // supply status
  output logic stby_ok,
  output logic at_strap
);
  int ramp_q = 0;
  initial stby_ok = 1'b0;
  assign at_strap = no_stby;
  // standby collapses with mains at once and ramps back after a delay
  always @(posedge clk) begin
    if (!mains_on) ramp_q <= 0;
    else if (ramp_q < 40) ramp_q <= ramp_q + 1;
    stby_ok <= mains_on && (ramp_q >= (slow ? 30 : 2));
  end
endmodule // pls_atx_supply
`default_nettype wire

//--- verification/tb_pls_supervisor.sv
// self-checking bench of the power loss state supervisor
`timescale 1ns/1ps
`default_nettype none
`include "pls_map.vh"
module tb_pls_supervisor;
  localparam int W = 50;
  logic clk = 0, rst = 1, pol_wr = 0, pwrbtn = 0, slpbtn = 0, smb_n = 1, wake = 0, off = 0;
  logic slp = 0, deep = 0, s5e = 0, mains = 1, slow = 0, no_stby = 0, stby, at_s;
  logic [1:0] pol = 0, slp_t = 0, rtype, pact;
  logic pwr, isl, ctx, s5a, loss, poff, wev, lon;
  int error_cnt = 0, tests_run = 0, poff_n = 0;
  initial forever #10 clk = ~clk;
  pls_supervisor #(.WATCH_CYCLES(W)) DUT (
    .REF_CLK(clk), .RST(rst), .STBY_OK(stby), .AT_SUPPLY(at_s), .POLICY(pol), .POLICY_WR(pol_wr),
    .PWRBTN_EVT(pwrbtn), .SLPBTN_EVT(slpbtn), .SMBALERT_N(smb_n), .WAKE_REQ(wake), .OFF_REQ(off),
    .SLEEP_REQ(slp), .SLP_TYPE(slp_t), .DEEP_REQ(deep), .S5E_EN(s5e), .SYS_PWR_EN(pwr),
    .ISLAND_ONLY(isl), .CTX_RETAIN(ctx), .RESUME_TYPE(rtype), .S5E_ACTIVE(s5a), .LOSS_EVT(loss),
    .PROPER_OFF_EVT(poff), .WAKE_EVT(wev), .LAST_ON(lon), .POLICY_ACT(pact));
  pls_atx_supply u_supply (.clk(clk), .mains_on(mains), .slow(slow), .no_stby(no_stby),
    .stby_ok(stby), .at_strap(at_s));
  always @(posedge clk) if (poff) poff_n <= poff_n + 1;
  // ****
  // helpers
  // ****
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task check(input string nm, input logic seen, input logic exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %b seen %b", nm, exp, seen);
    end
  endtask
  function logic sig(input int k);
    case (k)
      0: sig = pwr;
      1: sig = loss;
      2: sig = poff;
      default: sig = wev;
    endcase
  endfunction
  task wait_hi(input int k, input int lim);
    for (int i = 0; i < lim && sig(k) !== 1'b1; i++) tick(1);
    check("wait", sig(k), 1);
  endtask
  // request pulses: 0 power, 1 sleep button, 2 alert, 3 off, 4 wake, 5 deep, 6 policy
  task req(input int k);
    case (k)
      0: pwrbtn = 1;
      1: slpbtn = 1;
      2: smb_n = 0;
      3: off = 1;
      4: wake = 1;
      5: deep = 1;
      default: pol_wr = 1;
    endcase
    tick(1);
    {pwrbtn, slpbtn, off, wake, deep, pol_wr} = 6'h00;
    smb_n = 1;
  endtask
  task set_pol(input logic [1:0] p);
    pol = p;
    req(6);
    tick(3);
    check("policy", pact == p, 1);
  endtask
  task power_on;
    if (pwr !== 1'b1) req(0);
    wait_hi(0, 10);
    tick(1);
  endtask
  task do_reset;
    rst = 1;
    tick(20);
    rst = 0;
    tick(4);
  endtask
  task summarize;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ****
  // scenarios
  // ****
  task t_proper_off;
    int n;
    set_pol(`PLS_POL_TURN_ON);
    power_on;
    check("last_on", lon, 1);
    n = poff_n;
    req(3);
    tick(W - 5);
    check("early", poff_n == n, 1);
    wait_hi(2, 20);
    tick(2);
    check("last_off", lon, 0);
    mains = 0;
    tick(10);
    mains = 1;
    tick(20);
    check("stay_off", pwr, 0);
    $display("t_proper_off done");
  endtask
  task t_loss;
    for (int p = 0; p < 3; p++) begin
      set_pol(p[1:0]);
      power_on;
      mains = 0;
      wait_hi(1, 8);
      check("dark", pwr, 0);
      slow = p[0];
      tick(3);
      mains = 1;
      tick(45);
      check("recover", pwr, p != 1);
    end
    slow = 0;
    $display("t_loss done");
  endtask
  task t_window;
    int n;
    set_pol(`PLS_POL_LAST_STATE);
    power_on;
    n = poff_n;
    req(3);
    tick(10);
    mains = 0;
    wait_hi(1, 8);
    check("last_kept", lon, 1);
    mains = 1;
    tick(45);
    check("no_proper", poff_n == n, 1);
    check("back_on", pwr, 1);
    $display("t_window done");
  endtask
  task t_boot;
    set_pol(`PLS_POL_TURN_ON);
    power_on;
    mains = 0;
    wait_hi(1, 8);
    tick(2);
    rst = 1;
    tick(20);
    mains = 1;
    tick(10);
    rst = 0;
    wait_hi(0, 10);
    check("pol_kept", pact == `PLS_POL_TURN_ON, 1);
    $display("t_boot done");
  endtask
  task t_at;
    no_stby = 1;
    set_pol(`PLS_POL_REMAIN_OFF);
    do_reset;
    power_on;
    mains = 0;
    wait_hi(1, 8);
    mains = 1;
    tick(45);
    check("at_on", pwr, 1);
    no_stby = 0;
    do_reset;
    $display("t_at done");
  endtask
  task t_deep;
    for (int t = 1; t < 3; t++) begin
      power_on;
      req(5);
      tick(3);
      check("deep_refused", isl, 0);
      slp_t = t[1:0];
      slp = 1;
      tick(1);
      slp = 0;
      tick(3);
      req(5);
      tick(3);
      check("island", isl && !pwr, 1);
      check("context", ctx, t == 1);
      req(4);
      wait_hi(3, 6);
      check("resume", rtype == t[1:0] && !isl && !pwr, 1);
      req(4);
      wait_hi(0, 6);
    end
    $display("t_deep done");
  endtask
  task t_s5e;
    s5e = 1;
    for (int k = 0; k < 3; k++) begin
      power_on;
      req(3);
      wait_hi(2, W + 10);
      tick(2);
      check("s5e", s5a, 1);
      req(k);
      wait_hi(0, 6);
    end
    s5e = 0;
    $display("t_s5e done");
  endtask
  initial begin
    tick(20);
    rst = 0;
    tick(4);
    t_proper_off;
    t_loss;
    t_window;
    t_boot;
    t_at;
    t_deep;
    t_s5e;
    summarize;
  end
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    summarize;
  end
endmodule // tb_pls_supervisor
`default_nettype wire
